// [hw/hspc_host_spi_command_port.sv]
// Host serial command port: frame capture, register bank, slot queues
// Functional notes
// R1: Frames are exactly 16 or 32 clocks
// R2: Host holds select low during whole frame
// R3: Command bit 7 writes; bits 6-0 point
// R4: Further data bytes go to next register
// R5: Four-slot circular transmit queue per channel
// R6: Responses kept in order, read back later
// R7: Writes to occupied command slot ignored
// R8: Eight zero bits returned during command byte
// R9: Write stores byte, returns previous contents
// R10: Bad clock count flags error, no change
// R11: Short read returns value frozen at select fall
// R12: Short frame off control region is error
// R13: Long word: high, low, status; fourth ignored
// R14: Long control access covers three consecutive registers
// R15: Enhanced format only for slots, 10-bit command
// R16: Enhanced reply: responder nibble, zeros, data, status
// R17: Slot status frozen when select falls
// R18: Host checks transmit-empty before writing slots
// R19: Response arrival sets receive-not-empty
// R20: Commands issue only after select rises, no error
// R21: MSB first; partial frame dropped at select rise
module hspc_host_spi_command_port (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic host_port_clk,
    input wire logic host_select_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic [hspc_pkg::NUM_CH-1:0] cmd_valid,
    output hspc_pkg::hspc_cmd_t [hspc_pkg::NUM_CH-1:0] cmd_data,
    input wire logic [hspc_pkg::NUM_CH-1:0] cmd_ready,
    input wire logic [hspc_pkg::NUM_CH-1:0] rsp_valid,
    input wire hspc_pkg::hspc_rsp_t [hspc_pkg::NUM_CH-1:0] rsp_in,
    output logic [hspc_pkg::CTRL_COUNT-1:0][7:0] ctrl_regs,
    output logic framing_error
);
    // Link domain state
    logic link_rst_n;
    logic [5:0] bit_cnt;
    logic [5:0] frame_len;
    logic [7:0] rx_shift;
    logic [7:0] cmd_l;
    logic [7:0] d1_l;
    logic [7:0] d2_l;
    logic frame_tog;
    logic [5:0] next_cnt;
    logic [7:0] rx_byte;

    // Reference domain state
    logic sel_s;
    logic sel_q;
    logic tog_s;
    logic tog_seen;
    hspc_pkg::hspc_slot_t [hspc_pkg::NUM_SLOTS-1:0] slot;
    hspc_pkg::hspc_slot_t [hspc_pkg::NUM_SLOTS-1:0] next_slot;
    hspc_pkg::hspc_slot_t [hspc_pkg::NUM_SLOTS-1:0] slot_img;
    logic [hspc_pkg::CTRL_COUNT-1:0][7:0] ctrl_img;
    logic [hspc_pkg::CTRL_COUNT-1:0][7:0] next_ctrl;
    logic [hspc_pkg::NUM_CH-1:0][1:0] sp;
    logic [hspc_pkg::NUM_CH-1:0][1:0] next_sp;
    logic [hspc_pkg::NUM_CH-1:0][1:0] isl;
    logic [hspc_pkg::NUM_CH-1:0][1:0] next_isl;
    logic [hspc_pkg::NUM_CH-1:0] infl;
    logic [hspc_pkg::NUM_CH-1:0] next_infl;
    logic [hspc_pkg::NUM_CH-1:0] next_valid;
    hspc_pkg::hspc_cmd_t [hspc_pkg::NUM_CH-1:0] next_data;
    logic [hspc_pkg::NUM_CH-1:0][3:0] send_idx;
    logic [hspc_pkg::NUM_CH-1:0][3:0] rsp_idx;
    logic [hspc_pkg::NUM_CH-1:0] ch_pending;

    // Command decode, shared by both domains while frozen
    logic [6:0] addr;
    logic [6:0] addr1;
    logic [6:0] addr2;
    logic is_ctrl;
    logic is_slot;
    logic is_write;
    logic [3:0] wi;
    logic enh_img;
    logic enh_live;

    assign addr = cmd_l[6:0]; // R3
    assign addr1 = addr + 7'h01; // R4
    assign addr2 = addr + 7'h02; // R4
    assign is_write = cmd_l[hspc_pkg::WR_BIT]; // R3
    assign is_ctrl = addr < hspc_pkg::CTRL_LIMIT;
    assign is_slot = addr[hspc_pkg::SLOT_REGION_BIT];
    assign wi = addr[5:2];
    assign enh_img = ctrl_img[hspc_pkg::CTRL_MODE_IDX][addr[5:4]];
    assign enh_live = ctrl_regs[hspc_pkg::CTRL_MODE_IDX][addr[5:4]];

    // Link side: count and shift, MSB first
    assign link_rst_n = resetn & ~host_select_n; // R21
    assign next_cnt = (bit_cnt == hspc_pkg::CNT_MAX) ? bit_cnt : bit_cnt + 6'h01;
    assign rx_byte = {rx_shift[6:0], mosi}; // R21

    always_ff @(posedge host_port_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt <= 6'h00;
        end else begin
            bit_cnt <= next_cnt;
        end
    end

    // Captured frame; stays still while select is high because the clock stops
    always_ff @(posedge host_port_clk or negedge resetn) begin
        if (!resetn) begin
            frame_len <= 6'h00;
            rx_shift <= 8'h00;
            cmd_l <= 8'h00;
            d1_l <= 8'h00;
            d2_l <= 8'h00;
            frame_tog <= 1'b0;
        end else begin
            frame_len <= next_cnt; // R10
            rx_shift <= rx_byte; // R14
            if (bit_cnt == 6'h00) frame_tog <= ~frame_tog;
            if (bit_cnt == hspc_pkg::CMD_LAST) cmd_l <= rx_byte;
            if (bit_cnt == hspc_pkg::D1_LAST) d1_l <= rx_byte;
            if (bit_cnt == hspc_pkg::D2_LAST) d2_l <= rx_byte;
        end
    end

    // Read-back bytes from the image frozen at select fall
    hspc_pkg::hspc_slot_t rs;
    logic [7:0] rs_stat;
    logic [7:0] ctrl_b1;
    logic [7:0] ctrl_b2;
    logic [7:0] ctrl_b3;
    logic [7:0] rd_b1;
    logic [7:0] rd_b2;
    logic [7:0] rd_b3;
    logic [7:0] tx_byte;
    logic tx_bit;

    assign rs = slot_img[wi]; // R17
    assign rs_stat = {rs.rsp.crc_error, ~rs.pending, rs.rsp.signal_fault, rs.receive_not_empty_flag, rs.rsp.current_limit, 1'b0,
                      enh_img ? hspc_pkg::FIXED_A : hspc_pkg::FIXED_B,
                      enh_img ? hspc_pkg::FIXED_B : hspc_pkg::FIXED_A}; // R17
    assign ctrl_b1 = is_ctrl ? ctrl_img[addr[3:0]] : 8'h00; // R11
    assign ctrl_b2 = (addr1 < hspc_pkg::CTRL_LIMIT) ? ctrl_img[addr1[3:0]] : 8'h00; // R14
    assign ctrl_b3 = (addr2 < hspc_pkg::CTRL_LIMIT) ? ctrl_img[addr2[3:0]] : 8'h00; // R14
    assign rd_b1 = !is_slot ? ctrl_b1 : enh_img ? {rs.rsp.responder, 2'b00, rs.rsp.data[9:8]} // R16
                 : rs.rsp.data[15:8]; // R13
    assign rd_b2 = is_slot ? rs.rsp.data[7:0] : ctrl_b2; // R13
    assign rd_b3 = is_slot ? rs_stat : ctrl_b3; // R13
    assign tx_byte = (bit_cnt[5:3] == 3'h1) ? rd_b1 : (bit_cnt[5:3] == 3'h2) ? rd_b2
                   : (bit_cnt[5:3] == 3'h3) ? rd_b3 : 8'h00; // R8
    assign tx_bit = tx_byte[3'h7 - bit_cnt[2:0]]; // R9

    always_ff @(negedge host_port_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            miso <= 1'b0;
        end else begin
            miso <= tx_bit; // R9
        end
    end

    // Crossings into the reference domain
    hspc_sync2 #(.W(1), .RESET_VAL(1'b1)) u_sel_sync (
        .clk(ref_clk),
        .rst_n(resetn),
        .d(host_select_n),
        .q(sel_s)
    );

    hspc_sync2 #(.W(1), .RESET_VAL(1'b0)) u_tog_sync (
        .clk(ref_clk),
        .rst_n(resetn),
        .d(frame_tog),
        .q(tog_s)
    );

    // Frame checks at select rise
    logic frame_end;
    logic new_frame;
    logic is_short;
    logic is_long;
    logic frame_good;
    logic ctrl_wr;
    logic slot_wr;
    logic slot_rd;

    assign frame_end = sel_s & ~sel_q;
    assign new_frame = tog_s != tog_seen;
    assign is_short = frame_len == hspc_pkg::LEN_SHORT; // R1
    assign is_long = frame_len == hspc_pkg::LEN_LONG; // R1
    assign frame_good = new_frame & ((is_short & is_ctrl) | (is_long & (is_ctrl | is_slot))); // R10 R12 R15
    assign ctrl_wr = frame_end & frame_good & is_write & is_ctrl;
    assign slot_wr = frame_end & frame_good & is_write & is_slot;
    assign slot_rd = frame_end & frame_good & ~is_write & is_slot;

    always_comb begin
        next_ctrl = ctrl_regs;
        if (ctrl_wr) begin
            next_ctrl[addr[3:0]] = d1_l; // R9
            if (is_long && addr1 < hspc_pkg::CTRL_LIMIT) next_ctrl[addr1[3:0]] = d2_l; // R14
            if (is_long && addr2 < hspc_pkg::CTRL_LIMIT) next_ctrl[addr2[3:0]] = rx_shift; // R14
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < hspc_pkg::NUM_CH; gc = gc + 1) begin : g_ch
            assign send_idx[gc] = {2'(gc), sp[gc]};
            assign rsp_idx[gc] = {2'(gc), isl[gc]};
            assign ch_pending[gc] = slot[gc * 4].pending | slot[gc * 4 + 1].pending
                                  | slot[gc * 4 + 2].pending | slot[gc * 4 + 3].pending;

            a_cmd_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
                cmd_valid[gc] && !cmd_ready[gc] |=> cmd_valid[gc] && $stable(cmd_data[gc])) // R5
                else $error("command dropped before acceptance");
            a_issue_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
                $rose(cmd_valid[gc]) |-> $past(sel_s) && !$past(infl[gc])) // R20
                else $error("command issued during a frame or while busy");
            a_rne_set: assert property (@(posedge ref_clk) disable iff (!resetn)
                rsp_valid[gc] && infl[gc] |=> slot[$past(rsp_idx[gc])].receive_not_empty_flag && !infl[gc]) // R19
                else $error("response did not mark its slot");
        end
    endgenerate

    // Slot contents: write, read-clear, dispatch, response
    always_comb begin
        next_slot = slot;
        if (slot_wr && !slot[wi].pending) begin // R7
            next_slot[wi].cmd = enh_live ? {6'h00, d1_l[1:0], d2_l} : {d1_l, d2_l}; // R15 R13
            next_slot[wi].pending = 1'b1;
        end
        if (slot_rd) next_slot[wi].receive_not_empty_flag = 1'b0; // R6
        for (int c = 0; c < hspc_pkg::NUM_CH; c++) begin
            if (cmd_valid[c] && cmd_ready[c]) next_slot[send_idx[c]].pending = 1'b0;
            if (rsp_valid[c] && infl[c]) begin
                next_slot[rsp_idx[c]].rsp = rsp_in[c]; // R6
                next_slot[rsp_idx[c]].receive_not_empty_flag = 1'b1; // R19
            end
        end
    end

    // Circular dispatch per channel
    always_comb begin
        next_valid = cmd_valid;
        next_data = cmd_data;
        next_sp = sp;
        next_infl = infl;
        next_isl = isl;
        for (int c = 0; c < hspc_pkg::NUM_CH; c++) begin
            if (rsp_valid[c]) next_infl[c] = 1'b0;
            if (cmd_valid[c]) begin
                if (cmd_ready[c]) begin
                    next_valid[c] = 1'b0;
                    next_infl[c] = 1'b1;
                    next_isl[c] = sp[c];
                    next_sp[c] = 2'(sp[c] + 2'h1); // R5
                end
            end else if (!infl[c] && sel_s) begin // R20
                if (slot[send_idx[c]].pending) begin
                    next_valid[c] = 1'b1;
                    next_data[c].data = slot[send_idx[c]].cmd; // R5
                end else if (ch_pending[c]) begin
                    next_sp[c] = 2'(sp[c] + 2'h1); // R5
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 1'b1;
            tog_seen <= 1'b0;
            framing_error <= 1'b0;
            miso_oe <= 1'b0;
            ctrl_regs <= {hspc_pkg::CTRL_COUNT{hspc_pkg::CTRL_RESET}};
            ctrl_img <= {hspc_pkg::CTRL_COUNT{hspc_pkg::CTRL_RESET}};
            slot <= {hspc_pkg::NUM_SLOTS{hspc_pkg::SLOT_RESET}};
            slot_img <= {hspc_pkg::NUM_SLOTS{hspc_pkg::SLOT_RESET}};
        end else begin
            sel_q <= sel_s;
            if (frame_end) tog_seen <= tog_s; // R10
            miso_oe <= ~sel_s;
            if (frame_end) framing_error <= ~frame_good; // R10
            ctrl_regs <= next_ctrl;
            slot <= next_slot;
            if (sel_s) begin
                ctrl_img <= ctrl_regs; // R11
                slot_img <= slot; // R17
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_valid <= '0;
            cmd_data <= '0;
            sp <= '0;
            isl <= '0;
            infl <= '0;
        end else begin
            cmd_valid <= next_valid;
            cmd_data <= next_data;
            sp <= next_sp;
            isl <= next_isl;
            infl <= next_infl;
        end
    end

    a_cmd_zero: assert property (@(posedge host_port_clk) disable iff (!link_rst_n) // R8
        bit_cnt < hspc_pkg::CMD_BITS |-> miso == 1'b0)
        else $error("nonzero bit during command byte");
    a_len_error: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
        frame_end && !is_short && !is_long |=> framing_error && $stable(ctrl_regs) && $stable(slot))
        else $error("bad length not flagged or state changed");
    a_short_ctrl: assert property (@(posedge ref_clk) disable iff (!resetn) // R12
        frame_end && is_short && !is_ctrl |=> framing_error && $stable(ctrl_regs))
        else $error("short frame outside control region accepted");
    a_short_write: assert property (@(posedge ref_clk) disable iff (!resetn) // R9
        frame_end && frame_good && is_write && is_short |=> ctrl_regs[$past(addr[3:0])] == $past(d1_l))
        else $error("short write not stored");
    a_full_slot: assert property (@(posedge ref_clk) disable iff (!resetn) // R7
        frame_end && frame_good && is_write && is_slot && slot[wi].pending
        |=> slot[$past(wi)].cmd == $past(slot[wi].cmd))
        else $error("occupied slot overwritten");
    a_img_frozen: assert property (@(posedge ref_clk) disable iff (!resetn) // R17
        !sel_s |=> $stable(ctrl_img) && $stable(slot_img))
        else $error("read image moved during frame");
    a_long_ctrl: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
        frame_end && frame_good && is_write && is_long && is_ctrl && addr1 < hspc_pkg::CTRL_LIMIT
        |=> ctrl_regs[$past(addr1[3:0])] == $past(d2_l))
        else $error("second byte of long control write lost");

    c_short_write: cover property (@(posedge ref_clk) disable iff (!resetn)
        frame_end && frame_good && is_write && is_short);
    c_slot_write: cover property (@(posedge ref_clk) disable iff (!resetn) slot_wr ##[1:40] cmd_valid[0]);
    c_frame_err: cover property (@(posedge ref_clk) disable iff (!resetn) frame_end && !frame_good);
    c_slot_read: cover property (@(posedge ref_clk) disable iff (!resetn) slot_rd && slot[wi].receive_not_empty_flag);
endmodule : hspc_host_spi_command_port

// [hw/hspc_pkg.sv]
// Shared constants and carrier types of the host serial command port
package hspc_pkg;
    localparam int NUM_CH = 4;
    localparam int SLOTS_PER_CH = 4;
    localparam int NUM_SLOTS = 16;
    localparam int CTRL_COUNT = 16;
    localparam logic [5:0] LEN_SHORT = 6'h10;
    localparam logic [5:0] LEN_LONG = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [5:0] CMD_LAST = 6'h07;
    localparam logic [5:0] D1_LAST = 6'h0f;
    localparam logic [5:0] D2_LAST = 6'h17;
    localparam logic [5:0] D3_LAST = 6'h1f;
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam int WR_BIT = 7;
    localparam int SLOT_REGION_BIT = 6;
    localparam logic [6:0] CTRL_LIMIT = 7'h10;
    localparam logic [3:0] CTRL_MODE_IDX = 4'h0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic FIXED_A = 1'b0;
    localparam logic FIXED_B = 1'b1;

    typedef struct packed {
        logic [15:0] data;
    } hspc_cmd_t;

    typedef struct packed {
        logic [15:0] data;
        logic [3:0] responder;
        logic crc_error;
        logic signal_fault;
        logic current_limit;
    } hspc_rsp_t;

    typedef struct packed {
        logic [15:0] cmd;
        hspc_rsp_t rsp;
        logic pending;
        logic receive_not_empty_flag;
    } hspc_slot_t;

    localparam hspc_slot_t SLOT_RESET = '0;
endpackage : hspc_pkg

// [hw/hspc_sync2.sv]
// Two-flop synchroniser for levels and toggles
module hspc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : hspc_sync2

// [bench/hspc_host_model.sv]
// Serial host model that frames transfers to the command port
module hspc_host_model (
    input wire logic ref_clk,
    output logic host_port_clk,
    output logic host_select_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        host_port_clk = 1'b0;
        host_select_n = 1'b1;
        mosi = 1'b0;
    end

    // Runs n clocks at 6 ns; the clock stands still outside frames
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        @(negedge ref_clk);
        host_select_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < n; i++) begin
            mosi = tx[31 - (i % 32)];
            #3 host_port_clk = 1'b1;
            rx = {rx[30:0], miso};
            #3 host_port_clk = 1'b0;
        end
        #3 mosi = ~mosi;
        @(negedge ref_clk);
        host_select_n = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask : xfer
endmodule : hspc_host_model

// [bench/tb.sv]
// Self-checking bench of the host serial command port
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk, resetn, host_port_clk, host_select_n, mosi, miso, miso_oe, framing_error;
    logic [hspc_pkg::NUM_CH-1:0] cmd_valid, cmd_ready, rsp_valid;
    hspc_pkg::hspc_cmd_t [hspc_pkg::NUM_CH-1:0] cmd_data;
    hspc_pkg::hspc_rsp_t [hspc_pkg::NUM_CH-1:0] rsp_in;
    logic [hspc_pkg::CTRL_COUNT-1:0][7:0] ctrl_regs;
    logic [31:0] rx;
    int bad_count = 0;
    int comparisons = 0;
    int err_len [9] = '{0, 8, 15, 17, 24, 31, 33, 16, 32};
    logic [31:0] err_tx [9] = '{32'hc012_3456, 32'h85ff_ffff, 32'h85ff_ffff, 32'hc012_3456, 32'h81ff_ffff,
        32'hc012_3456, 32'h81ff_ffff, 32'hc0aa_0000, 32'h9077_0000};

    hspc_host_spi_command_port i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .host_port_clk(host_port_clk),
        .host_select_n(host_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_in(rsp_in), .ctrl_regs(ctrl_regs), .framing_error(framing_error)
    );

    hspc_host_model i_host (
        .ref_clk(ref_clk), .host_port_clk(host_port_clk), .host_select_n(host_select_n),
        .mosi(mosi), .miso(miso)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic done(input string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask : done

    // Waits for the channel's command, accepts it, then answers it
    task automatic serve(input int ch, input logic [15:0] exp, input hspc_pkg::hspc_rsp_t rsp);
        int n;
        n = 0;
        while (cmd_valid[ch] !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        check("cmd_valid up", cmd_valid[ch], 1'b1);
        check("cmd_data", cmd_data[ch].data, exp);
        cmd_ready[ch] = 1'b1;
        @(negedge ref_clk);
        cmd_ready[ch] = 1'b0;
        repeat (3) @(negedge ref_clk);
        check("cmd_valid in flight", cmd_valid[ch], 1'b0);
        rsp_in[ch] = rsp;
        rsp_valid[ch] = 1'b1;
        @(negedge ref_clk);
        rsp_valid[ch] = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : serve

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        bad_count++;
        $display("[ERR] watchdog expected end seen hang");
        finish_test();
    end

    initial begin
        resetn = 1'b0;
        cmd_ready = '0;
        rsp_valid = '0;
        rsp_in = '0;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
        check("reset error flag", framing_error, 1'b0);
        check("reset cmd_valid", cmd_valid, 4'h0);
        done("reset");

        fork
            i_host.xfer(16, 32'h855a_0000, rx);
            begin
                repeat (4) @(negedge ref_clk);
                check("miso_oe in frame", miso_oe, 1'b1);
            end
        join
        check("miso_oe idle", miso_oe, 1'b0);
        check("cmd byte zeros", rx[15:8], 8'h00);
        check("old ctrl5", rx[7:0], 8'h00);
        check("ctrl5", ctrl_regs[5], 8'h5a);
        check("short ok", framing_error, 1'b0);
        i_host.xfer(16, 32'h0500_0000, rx);
        check("read ctrl5", rx[7:0], 8'h5a);
        check("read keeps ctrl5", ctrl_regs[5], 8'h5a);
        done("short");

        i_host.xfer(32, 32'h8111_2233, rx);
        check("long old", rx, 32'h0);
        check("ctrl1 to 3", {ctrl_regs[1], ctrl_regs[2], ctrl_regs[3]}, 24'h112233);
        check("long ok", framing_error, 1'b0);
        i_host.xfer(32, 32'h0100_0000, rx);
        check("long read", rx, 32'h0011_2233);
        done("long control");

        for (int k = 0; k < 9; k++) begin
            i_host.xfer(err_len[k], err_tx[k], rx);
            check("error flag", framing_error, 1'b1);
            check("ctrl unchanged", {ctrl_regs[1], ctrl_regs[5]}, 16'h115a);
            check("no slot write", cmd_valid, 4'h0);
            i_host.xfer(16, 32'h0500_0000, rx);
            check("error cleared", framing_error, 1'b0);
        end
        done("framing");

        i_host.xfer(32, 32'h4000_0000, rx);
        check("slot empty", rx, 32'h0000_0042);
        i_host.xfer(32, 32'hc012_3400, rx);
        i_host.xfer(32, 32'hc0ab_cd00, rx);
        check("status full", rx[7:0], 8'h02);
        check("ignored ok", framing_error, 1'b0);
        i_host.xfer(32, 32'hc400_5600, rx);
        serve(0, 16'h1234, hspc_pkg::hspc_rsp_t'{16'hbeef, 4'h5, 1'b1, 1'b0, 1'b1});
        serve(0, 16'h0056, hspc_pkg::hspc_rsp_t'{16'h0102, 4'h0, 1'b0, 1'b1, 1'b0});
        i_host.xfer(32, 32'h4000_0000, rx);
        check("slot0 reply", rx, 32'h00be_efda);
        i_host.xfer(32, 32'h4000_0000, rx);
        check("slot0 drained", rx[7:0], 8'hca);
        i_host.xfer(32, 32'h4400_0000, rx);
        check("slot1 reply", rx, 32'h0001_0272);
        done("long slots");

        i_host.xfer(16, 32'h8002_0000, rx);
        i_host.xfer(32, 32'hd0ff_3c00, rx);
        serve(1, 16'h033c, hspc_pkg::hspc_rsp_t'{16'h02a5, 4'h9, 1'b0, 1'b0, 1'b0});
        i_host.xfer(32, 32'h5000_0000, rx);
        check("enhanced reply", rx, 32'h0092_a551);
        done("enhanced");
        finish_test();
    end
endmodule : tb
